// >>> verilog/ssd_pkg.sv
// Purpose: shared constants of the switch selected demo display
// Assumes: ref_clk of 10 MHz stands in for the on-chip oscillator
// Notes: How it works list below
//
// How it works
// - switch raised reads 1, depressed reads 0
// - code 0000 counts decimal up, 0001 down, range 0.0 to 9.9
// - counter holds a ones BCD digit and a tenths BCD digit
// - down loads 9.9, up loads 0.0 at reset and on rollover
// - counter and shifter step on slow tick or 5 MHz tick
// - 1100 core slow, 1001 io slow, 1000 core fast current meter
// - meter circuit on during each reading and while button pressed
// - meter rail powered only briefly: per request and after reset
// - an I2C master talks to the external power manager
// - 0010 shifts left, 0011 shifts right, slow tick
// - bit 21 is leftmost segment 7, bit 0 rightmost segment 1
// - zero enters MSB end on left, LSB end on right
// - shifter loads 1FFFFEh at reset and on rollover
// - 1010 usb voltage, 1011 battery voltage, rail as meter
// - 1111 is standby with no LCD output
// - unassigned codes are reserved, no LCD output
// - the reset button resets every module, timer included
// - output goes to an LCD of three characters
// - timer divided by 1024 to about 5 kHz then to under 2 Hz
// - three I2C cycles per reading, shown in microamp units
package ssd_pkg;
  // =====================================================
  // timing
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int FAST_CLK_HZ = 5_000_000;
  localparam int FAST_DIV = REF_CLK_HZ / FAST_CLK_HZ;
  localparam int TIMER_DIV = 1024;
  localparam int SLOW_DIV = 4096;
  localparam int I2C_HZ = 100_000;
  localparam int I2C_QTR_CYC = REF_CLK_HZ / (4 * I2C_HZ);
  localparam int PWR_SETTLE_US = 1000;
  localparam int PWR_SETTLE_CYC = PWR_SETTLE_US * (REF_CLK_HZ / 1_000_000);
  // =====================================================
  // mode codes
  localparam logic [3:0] MODE_UP = 4'h0;
  localparam logic [3:0] MODE_DOWN = 4'h1;
  localparam logic [3:0] MODE_LEFT = 4'h2;
  localparam logic [3:0] MODE_RIGHT = 4'h3;
  localparam logic [3:0] MODE_CORE_FAST = 4'h8;
  localparam logic [3:0] MODE_IO = 4'h9;
  localparam logic [3:0] MODE_USB = 4'ha;
  localparam logic [3:0] MODE_BAT = 4'hb;
  localparam logic [3:0] MODE_CORE_SLOW = 4'hc;
  localparam logic [3:0] MODE_STANDBY = 4'hf;
  // =====================================================
  // counter, shifter, display
  localparam logic [7:0] CNT_UP_INIT = 8'h00;
  localparam logic [7:0] CNT_DN_INIT = 8'h99;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam int SH_W = 22;
  localparam logic [21:0] SH_INIT = 22'h1ffffe;
  localparam logic [15:0] METER_MAX = 16'h03e7;
  // =====================================================
  // power manager access
  localparam logic [6:0] PM_DEV_ADDR = 7'h2a;
  localparam logic [7:0] PM_REG_ADC_CTRL = 8'h01;
  localparam logic [7:0] PM_REG_ADC_DATA = 8'h02;
  localparam logic [7:0] PM_ADC_START = 8'h10;
  localparam logic [3:0] CH_CORE = 4'h0;
  localparam logic [3:0] CH_IO = 4'h1;
  localparam logic [3:0] CH_USB = 4'h4;
  localparam logic [3:0] CH_BAT = 4'h5;
endpackage : ssd_pkg

// >>> verilog/ssd_onchip_osc_timer.sv
// Purpose: tick generator standing in for the on-chip oscillator/timer
// Assumes: one ref_clk domain
// Notes: ticks are one-cycle pulses from flip-flops
`timescale 1ns/1ps
module ssd_onchip_osc_timer
  import ssd_pkg::*;
#(
  parameter int FastDiv = FAST_DIV,
  parameter int TimerDiv = TIMER_DIV,
  parameter int SlowDiv = SLOW_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ticks
  output logic fastTick,
  output logic midTick,
  output logic slowTick
);
  logic [15:0] fastCnt_ff;
  logic [15:0] midCnt_ff;
  logic [15:0] slowCnt_ff;
  logic fastTick_ff;
  logic midTick_ff;
  logic slowTick_ff;

  // =====================================================
  // divider chain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fastCnt_ff <= 16'h0000;
      fastTick_ff <= 1'b0;
    end else begin
      fastTick_ff <= (fastCnt_ff == 16'(FastDiv - 1));
      fastCnt_ff <= (fastCnt_ff == 16'(FastDiv - 1)) ? 16'h0000 : fastCnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      midCnt_ff <= 16'h0000;
      midTick_ff <= 1'b0;
    end else begin
      midTick_ff <= fastTick_ff && (midCnt_ff == 16'(TimerDiv - 1));
      if (fastTick_ff) begin
        midCnt_ff <= (midCnt_ff == 16'(TimerDiv - 1)) ? 16'h0000 : midCnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slowCnt_ff <= 16'h0000;
      slowTick_ff <= 1'b0;
    end else begin
      slowTick_ff <= midTick_ff && (slowCnt_ff == 16'(SlowDiv - 1));
      if (midTick_ff) begin
        slowCnt_ff <= (slowCnt_ff == 16'(SlowDiv - 1)) ? 16'h0000 : slowCnt_ff + 16'h0001;
      end
    end
  end

  assign fastTick = fastTick_ff;
  assign midTick = midTick_ff;
  assign slowTick = slowTick_ff;
endmodule : ssd_onchip_osc_timer

// >>> verilog/ssd_i2c_master.sv
// Purpose: byte-level I2C master for one transaction per go pulse
// Assumes: no clock stretching by the slave
// Notes: address byte, then one or two data bytes, then stop
`timescale 1ns/1ps
module ssd_i2c_master
  import ssd_pkg::*;
#(
  parameter int QtrCyc = I2C_QTR_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request
  input wire logic go,
  input wire logic rdMode,
  input wire logic [1:0] nBytes,
  input wire logic [6:0] devAddr,
  input wire logic [7:0] wrByte1,
  input wire logic [7:0] wrByte2,
  // answer
  output logic busy,
  output logic done,
  output logic nackErr,
  output logic [15:0] rdWord,
  // bus pins
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  typedef enum logic [1:0] {I_IDLE, I_START, I_BITS, I_STOP} ssd_i2c_e;
  ssd_i2c_e state_ff;
  logic [7:0] qCnt_ff;
  logic [1:0] phase_ff;
  logic [3:0] bitIdx_ff;
  logic [1:0] byteIdx_ff;
  logic [7:0] shTx_ff;
  logic sclLow_ff;
  logic sdaLow_ff;
  logic done_ff;
  logic nack_ff;
  logic [15:0] rdWord_ff;
  logic qTick;
  logic rdByte;
  logic lastByte;

  assign qTick = (state_ff != I_IDLE) && (qCnt_ff == 8'(QtrCyc - 1));
  assign rdByte = rdMode && (byteIdx_ff != 2'h0);
  assign lastByte = (byteIdx_ff == nBytes);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      qCnt_ff <= 8'h00;
    end else begin
      qCnt_ff <= (qTick || state_ff == I_IDLE) ? 8'h00 : qCnt_ff + 8'h01;
    end
  end

  // =====================================================
  // bit sequencer
  // start, bytes with ack, stop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= I_IDLE;
      phase_ff <= 2'h0;
      bitIdx_ff <= 4'h0;
      byteIdx_ff <= 2'h0;
      shTx_ff <= 8'h00;
      sclLow_ff <= 1'b0;
      sdaLow_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      rdWord_ff <= 16'h0000;
    end else begin
      done_ff <= 1'b0;
      if (state_ff == I_IDLE) begin
        if (go) begin
          state_ff <= I_START;
          phase_ff <= 2'h0;
          byteIdx_ff <= 2'h0;
          bitIdx_ff <= 4'h0;
          nack_ff <= 1'b0;
          shTx_ff <= {devAddr, rdMode};
        end
      end else if (qTick) begin
        phase_ff <= phase_ff + 2'h1;
        case (state_ff)
          I_START: begin
            if (phase_ff == 2'h1) sdaLow_ff <= 1'b1;
            if (phase_ff == 2'h2) sclLow_ff <= 1'b1;
            if (phase_ff == 2'h3) state_ff <= I_BITS;
          end
          I_BITS: begin
            case (phase_ff)
              2'h0: begin
                if (bitIdx_ff != 4'h8) sdaLow_ff <= rdByte ? 1'b0 : ~shTx_ff[7];
                else sdaLow_ff <= rdByte && !lastByte;
              end
              2'h1: sclLow_ff <= 1'b0;
              2'h2: begin
                if (bitIdx_ff != 4'h8) shTx_ff <= {shTx_ff[6:0], sdaIn};
                else if (rdByte) rdWord_ff <= {rdWord_ff[7:0], shTx_ff};
                else if (sdaIn) nack_ff <= 1'b1;
              end
              default: begin
                sclLow_ff <= 1'b1;
                if (bitIdx_ff != 4'h8) begin
                  bitIdx_ff <= bitIdx_ff + 4'h1;
                end else if (lastByte) begin
                  state_ff <= I_STOP;
                end else begin
                  bitIdx_ff <= 4'h0;
                  byteIdx_ff <= byteIdx_ff + 2'h1;
                  shTx_ff <= (byteIdx_ff == 2'h0) ? wrByte1 : wrByte2;
                end
              end
            endcase
          end
          I_STOP: begin
            if (phase_ff == 2'h0) sdaLow_ff <= 1'b1;
            if (phase_ff == 2'h1) sclLow_ff <= 1'b0;
            if (phase_ff == 2'h2) sdaLow_ff <= 1'b0;
            if (phase_ff == 2'h3) begin
              state_ff <= I_IDLE;
              done_ff <= 1'b1;
            end
          end
          default: state_ff <= I_IDLE;
        endcase
      end
    end
  end

  assign busy = (state_ff != I_IDLE);
  assign done = done_ff;
  assign nackErr = nack_ff;
  assign rdWord = rdWord_ff;
  assign sclOut = 1'b0;
  assign sclOe = sclLow_ff;
  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow_ff;
endmodule : ssd_i2c_master

// >>> verilog/ssd_demo_top.sv
// Purpose: switch selected counter, shifter and meter display
// Assumes: rst is the manual reset button, switches asynchronous
// Notes: lcdSeg is a raw 22-segment image for the LCD driver
`timescale 1ns/1ps
module ssd_demo_top
  import ssd_pkg::*;
#(
  parameter int TimerDiv = TIMER_DIV,
  parameter int SlowDiv = SLOW_DIV,
  parameter int PwrSettleCyc = PWR_SETTLE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // mode switches
  input wire logic [3:0] modeSwitch,
  // display
  output logic [21:0] lcdSeg,
  output logic lcdOn,
  // power manager
  output logic pmRailEn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic meterNack
);
  typedef enum logic [2:0] {M_IDLE, M_SETTLE, M_CMD, M_PTR, M_READ} ssd_meter_e;

  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = 7'h00;
    endcase
  endfunction : seg7

  function automatic logic [11:0] bin2bcd(input logic [9:0] b);
    logic [21:0] s;
    s = {12'h000, b};
    for (int i = 0; i < 10; i++) begin
      if (s[13:10] > 4'h4) s[13:10] = s[13:10] + 4'h3;
      if (s[17:14] > 4'h4) s[17:14] = s[17:14] + 4'h3;
      if (s[21:18] > 4'h4) s[21:18] = s[21:18] + 4'h3;
      s = {s[20:0], 1'b0};
    end
    bin2bcd = s[21:10];
  endfunction : bin2bcd

  function automatic int dv(input logic [7:0] c);
    dv = int'(c[7:4]) * 10 + int'(c[3:0]);
  endfunction : dv

  logic [3:0] swMeta_ff;
  logic [3:0] swSync_ff;
  logic [3:0] mode;
  logic fastTick;
  logic slowTick;
  logic isMeter;
  logic isBlank;
  logic runEn;
  logic cntTick;
  logic cntStep;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] baseCnt;
  logic freshCnt_ff;
  logic [21:0] shift_ff;
  logic [21:0] nxt_shift;
  logic [21:0] shiftMove;
  logic [3:0] prevMode_ff;
  logic trigger;
  logic pending_ff;
  ssd_meter_e seq_ff;
  logic [31:0] settle_ff;
  logic railOn_ff;
  logic i2cGo_ff;
  logic [3:0] chan;
  logic [3:0] chan_ff;
  logic i2cDone;
  logic [15:0] rdWord;
  logic [11:0] meterBcd_ff;
  logic [21:0] lcdSeg_ff;
  logic lcdOn_ff;
  logic [1:0] goCnt_ff;

  // =====================================================
  // switch input
  // two-stage synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      swMeta_ff <= MODE_STANDBY;
      swSync_ff <= MODE_STANDBY;
    end else begin
      swMeta_ff <= modeSwitch;
      swSync_ff <= swMeta_ff;
    end
  end

  assign mode = swSync_ff;
  assign isMeter = (mode == MODE_CORE_SLOW) || (mode == MODE_IO) || (mode == MODE_CORE_FAST) ||
                   (mode == MODE_USB) || (mode == MODE_BAT);
  assign isBlank = !isMeter && (mode != MODE_UP) && (mode != MODE_DOWN) &&
                   (mode != MODE_LEFT) && (mode != MODE_RIGHT);
  assign runEn = !isBlank;

  // =====================================================
  // clock generation
  // timer reset by the button
  ssd_onchip_osc_timer #(
    .FastDiv(FAST_DIV),
    .TimerDiv(TimerDiv),
    .SlowDiv(SlowDiv)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .fastTick(fastTick),
    .midTick(),
    .slowTick(slowTick)
  );

  assign cntTick = (mode == MODE_CORE_FAST) ? fastTick : slowTick;
  assign cntStep = runEn && cntTick;

  // =====================================================
  // decimal counter
  // bcd step and rollover
  // down mode starts from 9.9 until the first step after reset
  assign baseCnt = (freshCnt_ff && mode == MODE_DOWN) ? CNT_DN_INIT : cnt_ff;
  always_comb begin
    nxt_cnt = baseCnt;
    if (mode == MODE_DOWN) begin
      if (baseCnt == CNT_UP_INIT) nxt_cnt = CNT_DN_INIT;
      else if (baseCnt[3:0] == 4'h0) nxt_cnt = {baseCnt[7:4] - 4'h1, BCD_NINE};
      else nxt_cnt = {baseCnt[7:4], baseCnt[3:0] - 4'h1};
    end else begin
      if (baseCnt == CNT_DN_INIT) nxt_cnt = CNT_UP_INIT;
      else if (baseCnt[3:0] == BCD_NINE) nxt_cnt = {baseCnt[7:4] + 4'h1, 4'h0};
      else nxt_cnt = {baseCnt[7:4], baseCnt[3:0] + 4'h1};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= CNT_UP_INIT;
      freshCnt_ff <= 1'b1;
    end else if (cntStep) begin
      cnt_ff <= nxt_cnt;
      freshCnt_ff <= 1'b0;
    end
  end

  // =====================================================
  // shift register
  // zero fill per direction
  assign shiftMove = (mode == MODE_RIGHT) ? {shift_ff[20:0], 1'b0} : {1'b0, shift_ff[21:1]};
  assign nxt_shift = (shiftMove == 22'h000000) ? SH_INIT : shiftMove;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= SH_INIT;
    end else if (cntStep) begin
      shift_ff <= nxt_shift;
    end
  end

  // =====================================================
  // meter sequencer
  // channel per meter mode
  always_comb begin
    case (mode)
      MODE_IO: chan = CH_IO;
      MODE_USB: chan = CH_USB;
      MODE_BAT: chan = CH_BAT;
      default: chan = CH_CORE;
    endcase
  end

  assign trigger = isMeter && (mode != prevMode_ff);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prevMode_ff <= MODE_STANDBY;
    end else begin
      prevMode_ff <= mode;
    end
  end

  // one reading after reset, request set wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_ff <= 1'b1;
    end else begin
      pending_ff <= trigger || (pending_ff && seq_ff != M_IDLE);
    end
  end

  // rail up, three bus cycles, rail down
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_ff <= M_IDLE;
      settle_ff <= 32'h00000000;
      railOn_ff <= 1'b0;
      i2cGo_ff <= 1'b0;
      chan_ff <= CH_CORE;
      meterBcd_ff <= 12'h000;
    end else begin
      i2cGo_ff <= 1'b0;
      case (seq_ff)
        M_IDLE: begin
          if (pending_ff) begin
            seq_ff <= M_SETTLE;
            railOn_ff <= 1'b1;
            settle_ff <= 32'h00000000;
            chan_ff <= chan;
          end
        end
        M_SETTLE: begin
          settle_ff <= settle_ff + 32'h00000001;
          if (settle_ff == 32'(PwrSettleCyc - 1)) begin
            seq_ff <= M_CMD;
            i2cGo_ff <= 1'b1;
          end
        end
        M_CMD: begin
          if (i2cDone) begin
            seq_ff <= M_PTR;
            i2cGo_ff <= 1'b1;
          end
        end
        M_PTR: begin
          if (i2cDone) begin
            seq_ff <= M_READ;
            i2cGo_ff <= 1'b1;
          end
        end
        M_READ: begin
          if (i2cDone) begin
            seq_ff <= M_IDLE;
            railOn_ff <= 1'b0;
            meterBcd_ff <= bin2bcd((rdWord > METER_MAX) ? METER_MAX[9:0] : rdWord[9:0]);
          end
        end
        default: seq_ff <= M_IDLE;
      endcase
    end
  end

  // circuit on while the button is held
  assign pmRailEn = railOn_ff || rst;

  // bus master to the power manager
  ssd_i2c_master #(
    .QtrCyc(I2C_QTR_CYC)
  ) u_i2c (
    .ref_clk(ref_clk),
    .rst(rst),
    .go(i2cGo_ff),
    .rdMode(seq_ff == M_READ),
    .nBytes((seq_ff == M_PTR) ? 2'h1 : 2'h2),
    .devAddr(PM_DEV_ADDR),
    .wrByte1((seq_ff == M_CMD) ? PM_REG_ADC_CTRL : PM_REG_ADC_DATA),
    .wrByte2(PM_ADC_START | {4'h0, chan_ff}),
    .busy(),
    .done(i2cDone),
    .nackErr(meterNack),
    .rdWord(rdWord),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe)
  );

  // =====================================================
  // display image
  // three characters plus point
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lcdSeg_ff <= 22'h000000;
      lcdOn_ff <= 1'b0;
    end else begin
      lcdOn_ff <= !isBlank;
      if (mode == MODE_UP || mode == MODE_DOWN) begin
        lcdSeg_ff <= {seg7(baseCnt[7:4]), 1'b1, seg7(baseCnt[3:0]), 7'h00};
      end else if (mode == MODE_LEFT || mode == MODE_RIGHT) begin
        lcdSeg_ff <= shift_ff;
      end else if (isMeter) begin
        lcdSeg_ff <= {seg7(meterBcd_ff[11:8]), 1'b0, seg7(meterBcd_ff[7:4]), seg7(meterBcd_ff[3:0])};
      end else begin
        lcdSeg_ff <= 22'h000000;
      end
    end
  end

  assign lcdSeg = lcdSeg_ff;
  assign lcdOn = lcdOn_ff;

  // =====================================================
  // checks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) goCnt_ff <= 2'h0;
    else if (seq_ff == M_IDLE) goCnt_ff <= 2'h0;
    else if (i2cGo_ff) goCnt_ff <= goCnt_ff + 2'h1;
  end

  property p_sync;
    @(posedge ref_clk) disable iff (rst)
    (!$past(rst, 1) && !$past(rst, 2)) |-> (mode == $past(modeSwitch, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("mode not two cycles behind switches");

  property p_cnt_up;
    @(posedge ref_clk) disable iff (rst)
    (cntStep && mode == MODE_UP && cnt_ff != CNT_DN_INIT) |=> (dv(cnt_ff) == dv($past(cnt_ff)) + 1);
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("up count step wrong");

  property p_cnt_roll;
    @(posedge ref_clk) disable iff (rst)
    (cntStep && mode == MODE_DOWN && baseCnt == CNT_UP_INIT) |=> (cnt_ff == CNT_DN_INIT);
  endproperty
  a_cnt_roll: assert property (p_cnt_roll) else $error("down rollover not 9.9");

  property p_sh_right;
    @(posedge ref_clk) disable iff (rst)
    (cntStep && mode == MODE_RIGHT && shift_ff[20:0] != 21'h000000) |=>
      (shift_ff == {$past(shift_ff[20:0]), 1'b0});
  endproperty
  a_sh_right: assert property (p_sh_right) else $error("right shift wrong");

  property p_sh_reload;
    @(posedge ref_clk) disable iff (rst)
    (cntStep && shiftMove == 22'h000000) |=> (shift_ff == SH_INIT);
  endproperty
  a_sh_reload: assert property (p_sh_reload) else $error("shift reload missing");

  property p_fast;
    @(posedge ref_clk) disable iff (rst)
    (mode == MODE_CORE_FAST && fastTick) |=> (cnt_ff != $past(cnt_ff));
  endproperty
  a_fast: assert property (p_fast) else $error("fast mode not on fast tick");

  property p_blank;
    @(posedge ref_clk) disable iff (rst)
    (mode == MODE_STANDBY || isBlank) |=> !lcdOn;
  endproperty
  a_blank: assert property (p_blank) else $error("lcd on in blank mode");

  property p_rail_req;
    @(posedge ref_clk) disable iff (rst)
    trigger |-> ##[0:2] pmRailEn;
  endproperty
  a_rail_req: assert property (p_rail_req) else $error("rail not on for meter request");

  property p_rail_bus;
    @(posedge ref_clk) disable iff (rst)
    i2cGo_ff |-> pmRailEn;
  endproperty
  a_rail_bus: assert property (p_rail_bus) else $error("bus cycle with rail off");

  property p_three;
    @(posedge ref_clk) disable iff (rst)
    (seq_ff == M_READ && i2cDone) |-> (goCnt_ff == 2'h3) ##1 !pmRailEn;
  endproperty
  a_three: assert property (p_three) else $error("reading not three bus cycles");

  c_up_roll: cover property (@(posedge ref_clk) disable iff (rst)
    cntStep && mode == MODE_UP && cnt_ff == CNT_DN_INIT);
  c_sh_reload: cover property (@(posedge ref_clk) disable iff (rst)
    cntStep && shiftMove == 22'h000000);
  c_meter_done: cover property (@(posedge ref_clk) disable iff (rst)
    seq_ff == M_READ && i2cDone);
  c_fast: cover property (@(posedge ref_clk) disable iff (rst)
    mode == MODE_CORE_FAST && cntStep);
endmodule : ssd_demo_top

// >>> testbench/ssd_pm_slave.sv
// Purpose: power manager I2C slave model
// Assumes: scl and sda pulled up, no stretching
// Notes: reports every address and write byte
`timescale 1ns/1ps
module ssd_pm_slave (
  // bus
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  output logic sdaDrv,
  // observed bytes
  output logic [7:0] byteVal,
  output logic [7:0] byteCnt
);
  int cnt = 0;
  logic first = 0;
  logic rd = 0;
  logic [15:0] dat;
  logic [7:0] sh;
  initial begin
    sdaDrv = 0;
    byteCnt = 0;
    byteVal = 0;
  end
  // ==========
  // start condition
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    first = 1;
    rd = 0;
    dat = 16'h0123;
  end
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    cnt = cnt + 1;
    if (cnt == 8 && !(rd && !first)) begin
      byteVal = sh;
      byteCnt = byteCnt + 8'h01;
      if (first) rd = sh[0];
    end
  end
  // ack, or read data msb first
  always @(negedge scl) begin
    if (cnt == 9) begin
      cnt = 0;
      first = 0;
    end
    if (cnt == 8) sdaDrv = !nak && !(rd && !first);
    else if (rd && !first) begin
      sdaDrv = !dat[15];
      dat = {dat[14:0], 1'b1};
    end else sdaDrv = 0;
  end
endmodule : ssd_pm_slave

// >>> testbench/tb.sv
// Purpose: self-checking bench of the demo top
// Assumes: shortened timer and settle counts
// Notes: expectations queued, monitor compares
`timescale 1ns/1ps
module tb;
  import ssd_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  logic nak = 0;
  logic [3:0] modeSwitch = 4'hf;
  logic [21:0] lcdSeg, prevSeg;
  logic lcdOn, pmRailEn, sclOe, sdaOe, meterNack, sdaDrv;
  logic [7:0] byteVal, byteCnt, prevCnt;
  logic [21:0] segQ[$];
  logic [7:0] byteQ[$];
  logic [3:0] rsv[7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hd, 4'he, 4'hf};
  logic [31:0] seed = 13;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  wire logic sda = ~(sdaOe | sdaDrv);
  wire logic scl = ~sclOe;
  ssd_demo_top #(.TimerDiv(4), .SlowDiv(4), .PwrSettleCyc(20)) ssd_demo_top_inst (.ref_clk(ref_clk), .rst(rst),
    .modeSwitch(modeSwitch), .lcdSeg(lcdSeg), .lcdOn(lcdOn), .pmRailEn(pmRailEn), .sclOut(), .sclOe(sclOe),
    .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .meterNack(meterNack));
  ssd_pm_slave ssd_pm_slave_inst (.scl(scl), .sda(sda), .nak(nak), .sdaDrv(sdaDrv), .byteVal(byteVal),
    .byteCnt(byteCnt));
  initial forever #50 ref_clk = ~ref_clk;
  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic chkVal(input logic [21:0] got, input logic [21:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkVal
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    chkVal({14'h0, got}, {14'h0, exp});
  endtask : chkByte
  task automatic summarize;
    $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic waitQ(input int n);
    for (int i = 0; i < n && segQ.size() + byteQ.size() > 0; i++) @(posedge ref_clk);
    chkVal(22'(segQ.size() + byteQ.size()), 22'h0);
  endtask : waitQ
  task automatic waitRail(input logic v, input int n);
    for (int i = 0; i < n && pmRailEn !== v; i++) @(posedge ref_clk);
  endtask : waitRail
  task automatic pulseRst(input logic [3:0] m);
    rst <= 1;
    @(posedge ref_clk);
    rst <= 0;
    modeSwitch <= m;
  endtask : pulseRst
  task automatic runShift(input logic [3:0] m, input bit toLsb);
    pulseRst(m);
    for (int k = 0; k <= 20; k++) segQ.push_back(toLsb ? 22'(SH_INIT >> k) : 22'(SH_INIT << k));
    segQ.push_back(SH_INIT);
    waitQ(1200);
  endtask : runShift
  // ==========
  // monitor and timeout
  always @(posedge ref_clk) begin
    if (lcdOn === 1'b1 && lcdSeg !== prevSeg && segQ.size() > 0) chkVal(lcdSeg, segQ.pop_front());
    if (byteCnt !== prevCnt && byteQ.size() > 0) chkByte(byteVal, byteQ.pop_front());
    prevSeg <= lcdSeg;
    prevCnt <= byteCnt;
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    chkVal({21'h0, pmRailEn}, 22'h1);
    chkVal({21'h0, lcdOn}, 22'h0);
    runShift(MODE_LEFT, 1);
    runShift(MODE_RIGHT, 0);
    pulseRst(MODE_DOWN);
    segQ = '{{7'h6f, 1'b1, 7'h6f, 7'h00}, {7'h6f, 1'b1, 7'h7f, 7'h00}};
    waitQ(200);
    pulseRst(MODE_UP);
    segQ = '{{7'h3f, 1'b1, 7'h3f, 7'h00}, {7'h3f, 1'b1, 7'h06, 7'h00}};
    waitQ(200);
    seed = xs(seed);
    for (int i = 0; i < 7; i++) begin
      modeSwitch <= rsv[(i + seed % 7) % 7];
      repeat (4) @(posedge ref_clk);
      chkVal(lcdSeg, 22'h0);
      chkVal({21'h0, lcdOn}, 22'h0);
    end
    waitRail(0, 30000);
    modeSwitch <= MODE_IO;
    byteQ = '{{PM_DEV_ADDR, 1'b0}, PM_REG_ADC_CTRL, PM_ADC_START | 8'(CH_IO), {PM_DEV_ADDR, 1'b0},
      PM_REG_ADC_DATA, {PM_DEV_ADDR, 1'b1}};
    segQ.push_back({7'h5b, 1'b0, 7'h6f, 7'h06});
    waitRail(1, 100);
    waitRail(0, 20000);
    waitQ(10);
    chkVal({21'h0, pmRailEn}, 22'h0);
    chkVal({21'h0, meterNack}, 22'h0);
    chkVal({21'h0, lcdOn}, 22'h1);
    nak <= 1;
    modeSwitch <= MODE_USB;
    waitRail(1, 100);
    waitRail(0, 20000);
    chkVal({21'h0, meterNack}, 22'h1);
    chkVal({21'h0, lcdOn}, 22'h1);
    modeSwitch <= MODE_CORE_FAST;
    waitRail(1, 100);
    chkVal({21'h0, pmRailEn}, 22'h1);
    waitRail(0, 20000);
    chkVal({21'h0, lcdOn}, 22'h1);
    summarize();
  end
endmodule : tb
